// ---- logic/rxsp_pkg.sv ----
// shared constants for the receive system signaling port
package rxsp_pkg;
	localparam int          NUM_LINKS       = 8;
	localparam int          LINKS_PER_GROUP = 4;
	localparam int          SLOT_BITS       = 8;
	localparam logic [2:0]  SIG_LSB_POS     = 3'h4;
	localparam logic [2:0]  SIG_MSB_POS     = 3'h7;
	localparam logic [2:0]  SLOT_LAST_BIT   = 3'h7;
	localparam logic [1:0]  GROUP_LAST_LINK = 2'h3;
	localparam logic [2:0]  FP_T1_EACH_F    = 3'h0;
	localparam logic [2:0]  FP_T1_EVERY2_F  = 3'h1;
	localparam logic [2:0]  FP_T1_MF_FIRST  = 3'h2;
	localparam logic [2:0]  FP_T1_EVERY2_MF = 3'h3;
	localparam logic [2:0]  FP_E1_BASIC     = 3'h0;
	localparam logic [2:0]  FP_E1_CRC_MF    = 3'h1;
	localparam logic [2:0]  FP_E1_SIG_MF    = 3'h2;
	localparam logic [2:0]  FP_E1_BOTH_MF   = 3'h3;
	localparam logic [2:0]  FP_E1_TS1_TS16  = 3'h4;
	localparam int          FRAME_PERIOD_US = 125;
	localparam int          CLK_PERIOD_PS   = 4000;
	localparam int          FRAME_CYCLES    = FRAME_PERIOD_US * 1000000 / CLK_PERIOD_PS;
endpackage

// ---- logic/rxsp_link_edge.sv ----
// synchroniser and rising edge finder for one external clock or pulse pin
`timescale 1ns/1ps
module rxsp_link_edge (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic meta;
	logic sync;
	logic last;
	logic next_meta;
	logic next_sync;
	logic next_last;

	always_comb begin
		next_meta = pin;
		next_sync = meta;
		next_last = sync;
	end

	// meta feeds only sync
	always_ff @(posedge ref_clk or negedge nrst) begin
		// start at the pull-up idle level, so an idle-high pin gives no false edge after reset
		if (!nrst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			last <= 1'b1;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			last <= next_last;
		end
	end

	assign level = sync;
	assign rise  = sync & ~last;
endmodule

// ---- logic/rxsp_top.sv ----
// receive system signaling port: per-link and multiplexed signaling, frame pulse and clock
// What this block does
// - master mode: each signaling output updates on its own link clock edge
// - signaling bits sit in slot bits 5 to 8 on the mux outputs only; per-link rx_sig_out passes line_sig unmasked
// - slave mode: select own link clock or link 1 clock for all
// - mux mode: links 1-4 on first pair, links 5-8 on second
// - mux signaling outputs update on multiplexed clock edge
// - primary and backup mux outputs carry identical content
// - T1 master: frame pulse marks selected F-bit or multiframe position
// - T1 slave: system drives frame start pulse, multiple of 125 us
// - E1 master: frame pulse marks basic, CRC, signaling, both, or TS1/TS16
// - E1 slave: system frame start pulse accepted as frame reference
// - frame pulse driven or sampled on its link clock edge
// - frame pulse active level follows per-link invert control
// - mux mode: system frame pulse sampled on multiplexed clock edge
// - master mode outside mux mode: device drives per-link clock, 1.544 or 2.048 MHz
// - master mode: data output updates on link clock edge
`timescale 1ns/1ps
module rxsp_top
	import rxsp_pkg::*;
(
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic                          clock_master,
	input  wire logic                          mux_mode,
	input  wire logic                          e1_mode,
	input  wire logic                          rx_slave_clock_share_sel,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] frame_pulse_invert,
	input  wire logic [2:0]                    frame_pulse_sel,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_clock_tick,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_data,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_sig,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_fbit,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_mf_start,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_mf2_start,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_sig_mf_start,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] line_ts_overhead,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] rx_sys_clock_in,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_sys_clock_out,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_sys_clock_oe,
	input  wire logic [rxsp_pkg::NUM_LINKS-1:0] rx_frame_pulse_in,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_frame_pulse_out,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_frame_pulse_oe,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_frame_start,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_sys_data_out,
	output logic      [rxsp_pkg::NUM_LINKS-1:0] rx_sig_out,
	input  wire logic                          mux_rx_sys_clock,
	input  wire logic                          mux_rx_frame_pulse,
	input  wire logic [rxsp_pkg::NUM_LINKS*rxsp_pkg::SLOT_BITS-1:0] mux_slot_data,
	input  wire logic [rxsp_pkg::NUM_LINKS*rxsp_pkg::SLOT_BITS-1:0] mux_slot_sig,
	output logic      [1:0]                    mux_rx_data_primary,
	output logic      [1:0]                    mux_rx_data_backup,
	output logic      [1:0]                    mux_rx_sig_primary,
	output logic      [1:0]                    mux_rx_sig_backup,
	output logic                               mux_frame_start
);
	import rxsp_pkg::*;

	// signaling nibble lives only in bits 5..8 (indices 4..7) of a slot
	function automatic logic sig_bit(input logic [SLOT_BITS-1:0] slot, input logic [2:0] pos);
		sig_bit = (pos >= SIG_LSB_POS && pos <= SIG_MSB_POS) ? slot[pos] : 1'b0;
	endfunction

	function automatic logic fp_event(input logic e1, input logic [2:0] sel, input logic fb,
		input logic mf, input logic mf2, input logic smf, input logic ts, input logic odd);
		if (e1) begin
			case (sel)
				FP_E1_BASIC:    fp_event = fb;
				FP_E1_CRC_MF:   fp_event = mf;
				FP_E1_SIG_MF:   fp_event = smf;
				FP_E1_BOTH_MF:  fp_event = mf & smf;
				FP_E1_TS1_TS16: fp_event = ts;
				default:        fp_event = fb;
			endcase
		end else begin
			case (sel)
				FP_T1_EACH_F:    fp_event = fb;
				FP_T1_EVERY2_F:  fp_event = fb & odd;
				FP_T1_MF_FIRST:  fp_event = mf;
				FP_T1_EVERY2_MF: fp_event = mf2;
				default:         fp_event = fb;
			endcase
		end
	endfunction

	logic [NUM_LINKS-1:0] ck_rise;
	logic [NUM_LINKS-1:0] fp_lvl;
	logic                 mck_rise;
	logic                 mfp_lvl;

	genvar g;
	generate
		for (g = 0; g < NUM_LINKS; g++) begin : g_sync
			rxsp_link_edge u_ck (.ref_clk(ref_clk), .nrst(nrst), .pin(rx_sys_clock_in[g]),
				.level(), .rise(ck_rise[g]));
			rxsp_link_edge u_fp (.ref_clk(ref_clk), .nrst(nrst), .pin(rx_frame_pulse_in[g]),
				.level(fp_lvl[g]), .rise());
		end
	endgenerate
	rxsp_link_edge u_mck (.ref_clk(ref_clk), .nrst(nrst), .pin(mux_rx_sys_clock),
		.level(), .rise(mck_rise));
	rxsp_link_edge u_mfp (.ref_clk(ref_clk), .nrst(nrst), .pin(mux_rx_frame_pulse),
		.level(mfp_lvl), .rise());

	// per-link state
	logic [NUM_LINKS-1:0] ck_out;
	logic [NUM_LINKS-1:0] ck_oe;
	logic [NUM_LINKS-1:0] fp_out;
	logic [NUM_LINKS-1:0] fp_oe;
	logic [NUM_LINKS-1:0] fstart;
	logic [NUM_LINKS-1:0] dout;
	logic [NUM_LINKS-1:0] sout;
	logic [NUM_LINKS-1:0] fodd;
	logic [NUM_LINKS-1:0] next_ck_out;
	logic [NUM_LINKS-1:0] next_ck_oe;
	logic [NUM_LINKS-1:0] next_fp_out;
	logic [NUM_LINKS-1:0] next_fp_oe;
	logic [NUM_LINKS-1:0] next_fstart;
	logic [NUM_LINKS-1:0] next_dout;
	logic [NUM_LINKS-1:0] next_sout;
	logic [NUM_LINKS-1:0] next_fodd;
	logic [NUM_LINKS-1:0] upd;

	always_comb begin
		for (int i = 0; i < NUM_LINKS; i++) begin
			// master: edge is the line tick; slave: own or shared link 1 clock
			if (clock_master)
				upd[i] = line_clock_tick[i];
			else if (rx_slave_clock_share_sel)
				upd[i] = ck_rise[0];
			else
				upd[i] = ck_rise[i];
			next_ck_oe[i]  = clock_master & ~mux_mode;
			// the driven clock toggles on each tick; gaps appear when ticks pause
			next_ck_out[i] = line_clock_tick[i] ? ~ck_out[i] : ck_out[i];
			next_fp_oe[i]  = clock_master & ~mux_mode;
			next_dout[i]   = upd[i] ? line_data[i] : dout[i];
			next_sout[i]   = upd[i] ? line_sig[i] : sout[i];
			next_fodd[i]   = (upd[i] & line_fbit[i]) ? ~fodd[i] : fodd[i];
			next_fp_out[i] = fp_out[i];
			if (upd[i] && clock_master)
				next_fp_out[i] = frame_pulse_invert[i] ^ fp_event(e1_mode, frame_pulse_sel,
					line_fbit[i], line_mf_start[i], line_mf2_start[i], line_sig_mf_start[i],
					line_ts_overhead[i], fodd[i]);
			// slave: frame start taken from the pulse level at the link clock edge
			next_fstart[i] = upd[i] & ~clock_master & (fp_lvl[i] ^ frame_pulse_invert[i]);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ck_out <= '0;
			ck_oe  <= '0;
			fp_out <= '0;
			fp_oe  <= '0;
			fstart <= '0;
			dout   <= '0;
			sout   <= '0;
			fodd   <= '0;
		end else begin
			ck_out <= next_ck_out;
			ck_oe  <= next_ck_oe;
			fp_out <= next_fp_out;
			fp_oe  <= next_fp_oe;
			fstart <= next_fstart;
			dout   <= next_dout;
			sout   <= next_sout;
			fodd   <= next_fodd;
		end
	end

	// multiplexed bus state: bit and link pointers, shared by both groups
	logic [2:0] bit_pos;
	logic [1:0] link_idx;
	logic [1:0] md_p;
	logic [1:0] ms_p;
	logic       mfs;
	logic [2:0] next_bit_pos;
	logic [1:0] next_link_idx;
	logic [1:0] next_md_p;
	logic [1:0] next_ms_p;
	logic       next_mfs;
	logic       mfp_act;

	always_comb begin
		mfp_act       = mfp_lvl ^ frame_pulse_invert[0];
		next_bit_pos  = bit_pos;
		next_link_idx = link_idx;
		next_md_p     = md_p;
		next_ms_p     = ms_p;
		next_mfs      = 1'b0;
		if (mux_mode && mck_rise) begin
			if (mfp_act) begin
				next_bit_pos  = 3'h0;
				next_link_idx = 2'h0;
				next_mfs      = 1'b1;
			end else if (bit_pos == SLOT_LAST_BIT) begin
				next_bit_pos  = 3'h0;
				next_link_idx = (link_idx == GROUP_LAST_LINK) ? 2'h0 : link_idx + 2'h1;
			end else begin
				next_bit_pos = bit_pos + 3'h1;
			end
			for (int grp = 0; grp < 2; grp++) begin
				// group 0 carries links 1-4, group 1 links 5-8
				next_md_p[grp] = mux_slot_data[(grp*LINKS_PER_GROUP + int'(next_link_idx))*SLOT_BITS
					+ int'(next_bit_pos)];
				next_ms_p[grp] = sig_bit(mux_slot_sig[(grp*LINKS_PER_GROUP + int'(next_link_idx))*SLOT_BITS
					+: SLOT_BITS], next_bit_pos);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bit_pos  <= 3'h0;
			link_idx <= 2'h0;
			md_p     <= 2'h0;
			ms_p     <= 2'h0;
			mfs      <= 1'b0;
		end else begin
			bit_pos  <= next_bit_pos;
			link_idx <= next_link_idx;
			md_p     <= next_md_p;
			ms_p     <= next_ms_p;
			mfs      <= next_mfs;
		end
	end

	// separate backup flops keep every output straight from a flip-flop
	logic [1:0] md_b;
	logic [1:0] ms_b;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			md_b <= 2'h0;
			ms_b <= 2'h0;
		end else begin
			md_b <= next_md_p;
			ms_b <= next_ms_p;
		end
	end

	assign rx_sys_clock_out    = ck_out;
	assign rx_sys_clock_oe     = ck_oe;
	assign rx_frame_pulse_out  = fp_out;
	assign rx_frame_pulse_oe   = fp_oe;
	assign rx_frame_start      = fstart;
	assign rx_sys_data_out     = dout;
	assign rx_sig_out          = sout;
	assign mux_rx_data_primary = md_p;
	assign mux_rx_data_backup  = md_b;
	assign mux_rx_sig_primary  = ms_p;
	assign mux_rx_sig_backup   = ms_b;
	assign mux_frame_start     = mfs;
endmodule

// ---- test/rxsp_top_sva.sv ----
// concurrent checks on the receive signaling port pins
`timescale 1ns/1ps
module rxsp_top_chk
	import rxsp_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       clock_master,
	input wire logic       mux_mode,
	input wire logic       e1_mode,
	input wire logic [7:0] frame_pulse_invert,
	input wire logic [2:0] frame_pulse_sel,
	input wire logic [7:0] line_clock_tick,
	input wire logic [7:0] line_data,
	input wire logic [7:0] line_sig,
	input wire logic [7:0] line_fbit,
	input wire logic       mux_rx_sys_clock,
	input wire logic [7:0] rx_sys_clock_out,
	input wire logic [7:0] rx_sys_clock_oe,
	input wire logic [7:0] rx_frame_pulse_out,
	input wire logic [7:0] rx_sys_data_out,
	input wire logic [7:0] rx_sig_out,
	input wire logic [1:0] mux_rx_data_primary,
	input wire logic [1:0] mux_rx_data_backup,
	input wire logic [1:0] mux_rx_sig_primary,
	input wire logic [1:0] mux_rx_sig_backup
);
	logic m;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	assign m = clock_master & ~mux_mode;
	chk_oe_mode: assert property ($past(nrst) |=> rx_sys_clock_oe == {8{$past(m)}})
		else $error("clock enable does not follow mode");
	chk_sig_update: assert property ($past(nrst) && m |=> rx_sig_out ==
		($past(line_clock_tick) & $past(line_sig) | ~$past(line_clock_tick) & $past(rx_sig_out)))
		else $error("signaling output off its tick");
	chk_data_update: assert property ($past(nrst) && m |=> rx_sys_data_out ==
		($past(line_clock_tick) & $past(line_data) | ~$past(line_clock_tick) & $past(rx_sys_data_out)))
		else $error("data output off its tick");
	chk_clk_toggle: assert property ($past(nrst) && m |=>
		rx_sys_clock_out == ($past(rx_sys_clock_out) ^ $past(line_clock_tick)))
		else $error("link clock out not toggling per tick");
	chk_fp_each_f: assert property ($past(nrst) && m && !e1_mode && frame_pulse_sel == FP_T1_EACH_F
		&& line_clock_tick[0] |=> rx_frame_pulse_out[0] == ($past(line_fbit[0]) ^ $past(frame_pulse_invert[0])))
		else $error("frame pulse wrong level");
	chk_mux_copy: assert property (mux_rx_data_backup == mux_rx_data_primary
		&& mux_rx_sig_backup == mux_rx_sig_primary)
		else $error("backup differs from primary");
	chk_mux_frozen: assert property ($past(nrst) && !mux_mode |=>
		$stable(mux_rx_sig_primary) && $stable(mux_rx_data_primary))
		else $error("mux outputs moved outside mux mode");
	chk_mux_edge: assert property ($past(nrst) && $changed(mux_rx_sig_primary) |->
		$past(mux_rx_sys_clock, 2) || $past(mux_rx_sys_clock, 3) || $past(mux_rx_sys_clock, 4))
		else $error("mux signaling moved without clock edge");
endmodule
bind rxsp_top rxsp_top_chk chk (.*);

// ---- test/rxsp_sys_model.sv ----
// system side model: link clocks, frame pulses and mux clock
`timescale 1ns/1ps
module rxsp_sys_model (
	output logic [7:0] clk_o,
	output logic [7:0] fp_o,
	output logic       mclk,
	output logic       mfp
);
	// clock pins rest high on their pull-ups; clocks stand still between frames
	initial begin
		clk_o = 8'hff;
		fp_o = 8'h00;
		mclk = 1'b1;
		mfp = 1'b0;
	end
	task automatic link_cycle(input logic [7:0] mask, input logic [7:0] fp);
		clk_o = ~mask;
		fp_o = fp;
		#62.5;
		clk_o = 8'hff;
		#62.5;
		fp_o = 8'h00;
	endtask
	task automatic mux_cycle(input logic fp);
		mclk = 1'b0;
		mfp = fp;
		#62.5;
		mclk = 1'b1;
		#62.5;
		mfp = 1'b0;
	endtask
endmodule

// ---- test/rxsp_top_tb_top.sv ----
// bench for the receive signaling port
`timescale 1ns/1ps
module rxsp_top_tb_top;
	import rxsp_pkg::*;
	typedef struct packed {logic e1; logic [2:0] sel; logic mk; logic [7:0] inv, dat, sig;} rxsp_row_s;
	localparam rxsp_row_s ROWS [8] = '{{1'b0, 3'h0, 1'b1, 8'h00, 8'ha5, 8'h3c}, {1'b0, 3'h2, 1'b0, 8'hff, 8'h5a, 8'hc3},
		{1'b0, 3'h3, 1'b1, 8'h0f, 8'hff, 8'h00}, {1'b1, 3'h0, 1'b1, 8'hf0, 8'h00, 8'hff},
		{1'b1, 3'h1, 1'b0, 8'h00, 8'h96, 8'h69}, {1'b1, 3'h2, 1'b1, 8'h55, 8'h69, 8'h96},
		{1'b1, 3'h3, 1'b1, 8'haa, 8'h0f, 8'hf0}, {1'b1, 3'h4, 1'b0, 8'h33, 8'hf0, 8'h0f}};
	localparam logic [24:0] SLV [3] = '{25'h000_ff00, 25'h1ff_01ff, 25'h000_01fe};
	logic        ref_clk = 1'b0, nrst = 1'b0, clock_master = 1'b1, mux_mode = 1'b0, e1_mode = 1'b0;
	logic        rx_slave_clock_share_sel = 1'b0, mk = 1'b0, ck = 1'b0, mux_frame_start;
	logic [2:0]  frame_pulse_sel = 3'h0;
	logic [7:0]  frame_pulse_invert = 8'h00, line_clock_tick = 8'h00, line_data = 8'h00, line_sig = 8'h00;
	logic [63:0] mux_slot_data = 64'hc3a5_0f96_5a3c_e187, mux_slot_sig = 64'h1e2d_3c4b_5a69_7887;
	wire logic [7:0] line_fbit = {8{mk}}, line_mf_start = {8{mk}}, line_mf2_start = {8{mk}};
	wire logic [7:0] line_sig_mf_start = {8{mk}}, line_ts_overhead = {8{mk}};
	wire logic [7:0] sck, sfp, rx_sys_clock_in, rx_frame_pulse_in;
	wire logic       mux_rx_sys_clock, mux_rx_frame_pulse;
	logic [7:0]  rx_sys_clock_out, rx_sys_clock_oe, rx_frame_pulse_out, rx_frame_pulse_oe, rx_frame_start;
	logic [7:0]  rx_sys_data_out, rx_sig_out;
	logic [1:0]  mux_rx_data_primary, mux_rx_data_backup, mux_rx_sig_primary, mux_rx_sig_backup;
	int          num_errors = 0, tests_run = 0, fs_n = 0, mfs_n = 0;
	// two-way pins: whichever side has the enable sets the wire
	assign rx_sys_clock_in = rx_sys_clock_oe & rx_sys_clock_out | ~rx_sys_clock_oe & sck;
	assign rx_frame_pulse_in = rx_frame_pulse_oe & rx_frame_pulse_out | ~rx_frame_pulse_oe & sfp;
	rxsp_top DUT (.*);
	rxsp_sys_model sys (.clk_o(sck), .fp_o(sfp), .mclk(mux_rx_sys_clock), .mfp(mux_rx_frame_pulse));
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (|rx_frame_start) fs_n++;
		if (mux_frame_start) mfs_n++;
	end
	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		conclude;
	end
	initial begin
		int li, bi;
		logic [7:0] fp_a;
		repeat (4) @(posedge ref_clk);
		#1 nrst = 1'b1;
		check({rx_sys_data_out, rx_sig_out, rx_frame_pulse_oe, mux_rx_data_primary}, 64'h0);
		for (int i = 0; i < 8; i++) begin
			{e1_mode, frame_pulse_sel, mk} = {ROWS[i].e1, ROWS[i].sel, ROWS[i].mk};
			{frame_pulse_invert, line_data, line_sig} = {ROWS[i].inv, ROWS[i].dat, ROWS[i].sig};
			line_clock_tick = 8'hff;
			step;
			line_clock_tick = 8'h00;
			step;
			ck = ~ck;
			check(rx_sys_data_out, ROWS[i].dat);
			check(rx_sig_out, ROWS[i].sig);
			check(rx_frame_pulse_out, ROWS[i].inv ^ {8{ROWS[i].mk}});
			check(rx_sys_clock_out, {8{ck}});
		end
		// every second F-bit: two F-bits in a row give opposite pulse levels
		{e1_mode, frame_pulse_sel, mk, frame_pulse_invert} = {1'b0, 3'h1, 1'b1, 8'h00};
		line_clock_tick = 8'hff;
		step;
		fp_a = rx_frame_pulse_out;
		step;
		check(rx_frame_pulse_out ^ fp_a, 8'hff);
		check({rx_sys_clock_oe, rx_frame_pulse_oe}, 16'hffff);
		// back-to-back ticks on different links must each land
		line_data = 8'hff;
		line_clock_tick = 8'h0f;
		step;
		line_data = 8'h00;
		line_clock_tick = 8'hf0;
		step;
		line_clock_tick = 8'h00;
		step;
		check(rx_sys_data_out, 8'h0f);
		{clock_master, frame_pulse_invert} = 9'h000;
		for (int i = 0; i < 3; i++) begin
			rx_slave_clock_share_sel = SLV[i][24];
			line_data = SLV[i][23:16];
			sys.link_cycle(SLV[i][15:8], 8'h00);
			step;
			check(rx_sys_data_out, SLV[i][7:0]);
		end
		fs_n = 0;
		sys.link_cycle(8'hff, 8'h04);
		step;
		check(fs_n, 1);
		frame_pulse_invert = 8'h04;
		sys.link_cycle(8'h04, 8'h00);
		step;
		check(fs_n, 2);
		{frame_pulse_invert, mux_mode} = 9'h001;
		for (int k = 0; k < 40; k++) begin
			sys.mux_cycle(k == 0);
			step;
			li = (k % 32) / 8;
			bi = k % 8;
			check(mux_rx_data_primary, {mux_slot_data[(li + 4) * 8 + bi], mux_slot_data[li * 8 + bi]});
			check(mux_rx_sig_backup, bi < 4 ? 2'b00 : {mux_slot_sig[(li + 4) * 8 + bi], mux_slot_sig[li * 8 + bi]});
		end
		check(mfs_n, 1);
		// a mid-run reset must clear the bus and leave no false clock edge behind
		nrst = 1'b0;
		step;
		check({rx_sys_data_out, rx_frame_start, mux_rx_data_primary, mux_rx_sig_backup}, 64'h0);
		nrst = 1'b1;
		repeat (4) step;
		check({mux_rx_data_primary, mux_rx_sig_primary, mux_frame_start}, 64'h0);
		conclude;
	end
endmodule
